/* scdg_cpu_model.sv */
// Core and interrupt source model: issues the sleep instruction, then interrupts.
// Assumes one go pulse per run and at least 32 cycles between runs.
`timescale 1ns/1ps
`default_nettype none
module scdg_cpu_model (
  input wire logic hclk,
  input wire logic go,
  input wire logic [2:0] mode,
  input wire logic pb,
  input wire logic sleeping,
  output logic sleep_req,
  output logic [2:0] sleep_arg,
  output logic [7:0] wake_irq,
  output logic [7:0] wake_domain_pb,
  output logic held
);
  // ====
  // Sleep and wake sequence
  initial begin
    sleep_req = 1'b0;
    sleep_arg = 3'h0;
    wake_irq = 8'h00;
    wake_domain_pb = 8'h0F;
    held = 1'b0;
  end
  always @(posedge hclk) begin
    if (go) begin
      sleep_req <= 1'b1;
      sleep_arg <= mode;
      @(posedge hclk);
      sleep_req <= 1'b0;
      repeat (6) @(posedge hclk);
      wake_irq <= pb ? 8'h01 : 8'h10;
      repeat (12) @(posedge hclk);
      held <= sleeping;
      // Level source off the bus domains, so the core always comes back
      wake_irq <= 8'h10;
      repeat (12) @(posedge hclk);
      wake_irq <= 8'h00;
    end
  end
endmodule // scdg_cpu_model
`default_nettype wire

/* scdg_div.sv */
// One clock domain enable generator driven by the shared prescaler.
// Assumes the prescaler count comes from the top-level counter; the tick is made here.
`timescale 1ns/1ps
`default_nettype none
module scdg_div (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [scdg_pkg::SCDG_PRESCALE_W-1:0] count,
  input wire logic [7:0] sel,
  input wire logic run,
  output logic tick
);
  import scdg_pkg::*;
  logic [SCDG_PRESCALE_W-1:0] mask;
  always_comb begin
    mask = 8'hFF >> (3'h7 - sel[SCDG_SEL_W-1:0]);
  end
  // ============================================================
  // Tick fires once per 2^(sel+1) main cycles, or every cycle undivided
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick <= 1'b0;
    end else if (!run) begin
      tick <= 1'b0;
    end else if (sel[SCDG_DIV_BIT]) begin
      tick <= ((count & mask) == 8'h00);
    end else begin
      tick <= 1'b1;
    end
  end
endmodule // scdg_div
`default_nettype wire

/* scdg_monitor.sv */
// Port checker for the clock divider, gating and sleep block.
// Assumes it is bound onto scdg_top and sees nothing but its ports.
`timescale 1ns/1ps
`default_nettype none
module scdg_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic sleep_req,
  input wire logic [scdg_pkg::SCDG_MODE_W-1:0] sleep_arg,
  input wire logic [scdg_pkg::SCDG_WAKE_W-1:0] wake_irq,
  input wire logic [scdg_pkg::SCDG_WAKE_W-1:0] wake_domain_pb,
  input wire logic [scdg_pkg::SCDG_SRC_W-1:0] main_clock_source_select,
  input wire logic [scdg_pkg::SCDG_DOMAINS-1:0] domain_tick,
  input wire logic [scdg_pkg::SCDG_MASK_W-1:0] cpu_clk_en,
  input wire logic [scdg_pkg::SCDG_MASK_W-1:0] hsb_clk_en,
  input wire logic [scdg_pkg::SCDG_MASK_W-1:0] pba_clk_en,
  input wire logic sleeping
);
  import scdg_pkg::*;
  logic mc_wr;
  logic [2:0] cyc;
  logic [SCDG_MODE_W-1:0] mode_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ====
  // Helpers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) cyc <= 3'h0;
    else if (cyc != 3'h7) cyc <= cyc + 3'h1;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) mc_wr <= 1'b0;
    else if (hsel && hready && htrans[1] && hwrite && haddr[7:0] == SCDG_MAIN_CLOCK_CONTROL)
      mc_wr <= 1'b1;
  end
  // Mode of the sleep actually entered; index 7 is dropped by the block
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) mode_q <= 3'h0;
    else if (sleep_req && !sleeping && sleep_arg != 3'h7) mode_q <= sleep_arg;
  end
  // ====
  // Assertions
  main_src_a: assert property (!mc_wr |-> main_clock_source_select == SCDG_SRC_SYSTEM_RC_OSCILLATOR)
    else $error("main clock left the RC oscillator without a write");
  reset_undiv_a: assert property (cyc == 3'h4 |-> domain_tick == 4'hF && cpu_clk_en == '1)
    else $error("domains not undivided and unmasked after reset");
  gate_tick_a: assert property (((cpu_clk_en & ~{32{domain_tick[0]}}) |
    (pba_clk_en & ~{32{domain_tick[2]}})) == 32'h0)
    else $error("module clock enable outside its domain tick");
  sleep_cpu_a: assert property (sleeping && $past(sleeping) && $past(sleeping, 2)
    |-> cpu_clk_en == '0)
    else $error("cpu clocks run during sleep");
  sleep_hsb_a: assert property (sleeping && $past(sleeping) && $past(sleeping, 2)
    && mode_q != 3'h0 |-> hsb_clk_en == '0)
    else $error("fast bus clocks run in a deeper sleep");
  enter_sleep_a: assert property (sleep_req && !sleeping && sleep_arg != 3'h7
    && wake_irq == 8'h00 |-> ##[1:3] sleeping)
    else $error("sleep request not taken");
  ignore_seven_a: assert property (sleep_req && !sleeping && sleep_arg == 3'h7 |=> !sleeping)
    else $error("sleep index seven entered sleep");
  wake_exit_a: assert property (sleeping && (wake_irq & ~wake_domain_pb) != 8'h00
    |-> ##[1:4] !sleeping)
    else $error("interrupt failed to end sleep");
  deep_nowake_a: assert property (sleeping && mode_q >= 3'h2 && wake_irq != 8'h00
    && (wake_irq & ~wake_domain_pb) == 8'h00 |=> sleeping)
    else $error("unclocked source woke the device");
endmodule // scdg_monitor
bind scdg_top scdg_monitor u_mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .sleep_req(sleep_req),
  .sleep_arg(sleep_arg), .wake_irq(wake_irq), .wake_domain_pb(wake_domain_pb),
  .main_clock_source_select(main_clock_source_select), .domain_tick(domain_tick),
  .cpu_clk_en(cpu_clk_en), .hsb_clk_en(hsb_clk_en), .pba_clk_en(pba_clk_en),
  .sleeping(sleeping));
`default_nettype wire

/* scdg_pkg.sv */
// Constants, register map and types for the synchronous clock divider and gating block.
// Assumes an AHB-Lite slave with 32-bit data; registers are one aligned word each.
// ============================================================
// How it works
// - Main clock defaults to system RC oscillator
// - Eight-bit prescaler, any tap per domain
// - Reset leaves every domain undivided
// - CPU clock is main over 2^(sel+1)
// - Peripheral buses divide the same way
// - New dividers apply to all domains together
// - Fast-bus select ignores writes, mirrors CPU
// - Ready flag reads zero while change pends
// - Ready interrupt fires when change applied
// - All module mask bits one after reset
// - Mask bit zero gates, one restores clock
// - Masked module stops, its access ignored
// - Masking own or bridge clock locks masks
// - Sleep halts CPU and stopped domains, overriding masks
// - Interrupt ends sleep and restarts domains
// - Unclocked sources cannot wake the device
// - Collect resets, record cause for software
// - One interrupt output line
// - Sleep index 0 to 6 accepted, stopping deepens up to index 2
package scdg_pkg;
  // ============================================================
  // Register byte offsets
  localparam logic [7:0] SCDG_MAIN_CLOCK_CONTROL = 8'h00;
  localparam logic [7:0] SCDG_CPU_SEL = 8'h04;
  localparam logic [7:0] SCDG_FAST_BUS_SEL = 8'h08;
  localparam logic [7:0] SCDG_PBA_SEL = 8'h0C;
  localparam logic [7:0] SCDG_PBB_SEL = 8'h10;
  localparam logic [7:0] SCDG_CPU_MASK = 8'h20;
  localparam logic [7:0] SCDG_HSB_MASK = 8'h24;
  localparam logic [7:0] SCDG_PBA_MASK = 8'h28;
  localparam logic [7:0] SCDG_PBB_MASK = 8'h2C;
  localparam logic [7:0] SCDG_IER = 8'h40;
  localparam logic [7:0] SCDG_IDR = 8'h44;
  localparam logic [7:0] SCDG_IMR = 8'h48;
  localparam logic [7:0] SCDG_ISR = 8'h4C;
  localparam logic [7:0] SCDG_ICR = 8'h50;
  localparam logic [7:0] SCDG_SLEEP = 8'h60;
  localparam logic [7:0] SCDG_RESET_CAUSE = 8'h64;
  // ============================================================
  // Field positions and widths
  localparam int SCDG_SEL_W = 3;
  localparam int SCDG_DIV_BIT = 7;
  localparam int SCDG_SRC_W = 3;
  localparam int SCDG_MASK_W = 32;
  localparam int SCDG_DOMAINS = 4;
  localparam int SCDG_PRESCALE_W = 8;
  localparam int SCDG_CLOCK_READY_FLAG_BIT = 5;
  localparam int SCDG_NUM_RST = 4;
  localparam int SCDG_PM_MASK_BIT = 0;
  localparam int SCDG_BRIDGE_MASK_BIT = 1;
  localparam int SCDG_WAKE_W = 8;
  localparam int SCDG_MODE_W = 3;
  // ============================================================
  // Reset values and the highest sleep index
  localparam logic [SCDG_SRC_W-1:0] SCDG_SRC_SYSTEM_RC_OSCILLATOR = 3'h0;
  localparam logic [7:0] SCDG_SEL_RESET = 8'h00;
  localparam logic [SCDG_MASK_W-1:0] SCDG_MASK_RESET = 32'hFFFFFFFF;
  localparam logic [SCDG_MODE_W-1:0] SCDG_MODE_MAX = 3'h6;
  // Domain indices
  localparam int SCDG_D_CPU = 0;
  localparam int SCDG_D_HSB = 1;
  localparam int SCDG_D_PBA = 2;
  localparam int SCDG_D_PBB = 3;
  // Cycles from select write to ready; covers one full 256 prescaler period
  localparam int SCDG_APPLY_CYCLES = 256;
  typedef enum logic [1:0] {SCDG_RUN, SCDG_PEND, SCDG_APPLY} scdg_state_e;
endpackage

/* scdg_reset.sv */
// Reset cause collector: records the last reset source for software.
// Assumes reset sources are synchronised pulses, external pin already filtered.
`timescale 1ns/1ps
`default_nettype none
module scdg_reset (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [scdg_pkg::SCDG_NUM_RST-1:0] sources,
  output logic soft_reset,
  output logic [scdg_pkg::SCDG_NUM_RST-1:0] cause
);
  import scdg_pkg::*;
  logic released;
  // ============================================================
  // Cause of a hard reset caught after release; sources 1 to 3, external pin included, while running
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      released <= 1'b0;
      cause <= '0;
      soft_reset <= 1'b0;
    end else begin
      released <= 1'b1;
      soft_reset <= |sources[SCDG_NUM_RST-1:1];
      if (!released) begin
        cause <= {sources[SCDG_NUM_RST-1:1], 1'b1};
      end else if (|sources[SCDG_NUM_RST-1:1]) begin
        cause <= sources;
      end
    end
  end
endmodule // scdg_reset
`default_nettype wire

/* scdg_top.sv */
// Clock divider, module clock gating, sleep and reset cause with an AHB-Lite slave.
// Assumes one main clock hclk; domain clocks leave as enables for downstream gates.
`timescale 1ns/1ps
`default_nettype none
module scdg_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic sleep_req,
  input wire logic [scdg_pkg::SCDG_MODE_W-1:0] sleep_arg,
  input wire logic [scdg_pkg::SCDG_WAKE_W-1:0] wake_irq,
  input wire logic [scdg_pkg::SCDG_WAKE_W-1:0] wake_domain_pb,
  input wire logic ext_reset_n,
  input wire logic [scdg_pkg::SCDG_NUM_RST-2:0] soft_sources,
  output logic [scdg_pkg::SCDG_SRC_W-1:0] main_clock_source_select,
  output logic [scdg_pkg::SCDG_DOMAINS-1:0] domain_tick,
  output logic [scdg_pkg::SCDG_MASK_W-1:0] cpu_clk_en,
  output logic [scdg_pkg::SCDG_MASK_W-1:0] hsb_clk_en,
  output logic [scdg_pkg::SCDG_MASK_W-1:0] pba_clk_en,
  output logic [scdg_pkg::SCDG_MASK_W-1:0] pbb_clk_en,
  output logic sleeping,
  output logic soft_reset,
  output logic irq
);
  import scdg_pkg::*;
  // ============================================================
  // Declarations
  logic [7:0] cpu_sel;
  logic [7:0] pba_sel;
  logic [7:0] pbb_sel;
  logic [7:0] act_cpu;
  logic [7:0] act_pba;
  logic [7:0] act_pbb;
  logic [SCDG_MASK_W-1:0] cpu_mask;
  logic [SCDG_MASK_W-1:0] hsb_mask;
  logic [SCDG_MASK_W-1:0] pba_mask;
  logic [SCDG_MASK_W-1:0] pbb_mask;
  logic clock_ready_flag;
  logic ready_event;
  logic interrupt_enable;
  logic [SCDG_MODE_W-1:0] sleep_mode;
  logic [SCDG_PRESCALE_W-1:0] prescale;
  logic [8:0] apply_cnt;
  scdg_state_e state;
  logic [SCDG_DOMAINS-1:0] run;
  logic [SCDG_DOMAINS-1:0] ticks;
  logic [SCDG_NUM_RST-1:0] cause;
  logic ext_rst_q1;
  logic ext_rst_q2;
  logic mask_lock;
  logic wake;
  logic ph_wr;
  logic ph_rd;
  logic [7:0] ph_addr;
  logic wr;
  logic sel_write;
  logic [31:0] next_rdata;
  // ============================================================
  // AHB-Lite address phase capture; reads take one wait state, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr <= 1'b0;
      ph_rd <= 1'b0;
      ph_addr <= 8'h00;
    end else if (hready) begin
      ph_wr <= hsel && htrans[1] && hwrite;
      ph_rd <= hsel && htrans[1] && !hwrite;
      ph_addr <= haddr[7:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      // Registered read data need one cycle after the address phase
      hreadyout <= !(hready && hsel && htrans[1] && !hwrite);
      hresp <= 1'b0;
    end
  end
  assign wr = ph_wr;
  // Select writes only counted while no change pends; protects against hangs
  assign sel_write = wr && (ph_addr == SCDG_CPU_SEL || ph_addr == SCDG_PBA_SEL ||
                            ph_addr == SCDG_PBB_SEL);
  // ============================================================
  // Main clock source and divider selections
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_clock_source_select <= SCDG_SRC_SYSTEM_RC_OSCILLATOR;
    end else if (wr && ph_addr == SCDG_MAIN_CLOCK_CONTROL) begin
      main_clock_source_select <= hwdata[SCDG_SRC_W-1:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_sel <= SCDG_SEL_RESET;
      pba_sel <= SCDG_SEL_RESET;
      pbb_sel <= SCDG_SEL_RESET;
    end else if (state == SCDG_RUN && wr) begin
      // Fast-bus select has no storage of its own
      if (ph_addr == SCDG_CPU_SEL) begin
        cpu_sel <= {hwdata[SCDG_DIV_BIT], 4'h0, hwdata[SCDG_SEL_W-1:0]};
      end
      if (ph_addr == SCDG_PBA_SEL) begin
        pba_sel <= {hwdata[SCDG_DIV_BIT], 4'h0, hwdata[SCDG_SEL_W-1:0]};
      end
      if (ph_addr == SCDG_PBB_SEL) begin
        pbb_sel <= {hwdata[SCDG_DIV_BIT], 4'h0, hwdata[SCDG_SEL_W-1:0]};
      end
    end
  end
  // ============================================================
  // Pending change: wait, then apply all domains in one prescaler wrap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= SCDG_RUN;
      apply_cnt <= 9'h000;
    end else begin
      unique case (state)
        SCDG_RUN: begin
          apply_cnt <= 9'h000;
          if (sel_write) begin
            state <= SCDG_PEND;
          end
        end
        SCDG_PEND: begin
          apply_cnt <= apply_cnt + 9'h001;
          if (prescale == 8'hFF) begin
            state <= SCDG_APPLY;
          end
        end
        SCDG_APPLY: begin
          state <= SCDG_RUN;
        end
      endcase
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_cpu <= SCDG_SEL_RESET;
      act_pba <= SCDG_SEL_RESET;
      act_pbb <= SCDG_SEL_RESET;
    end else if (state == SCDG_APPLY) begin
      act_cpu <= cpu_sel;
      act_pba <= pba_sel;
      act_pbb <= pbb_sel;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prescale <= 8'h00;
    end else begin
      prescale <= prescale + 8'h01;
    end
  end
  // ============================================================
  // Ready flag, sticky event and interrupt; set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_ready_flag <= 1'b1;
    end else if (sel_write && state == SCDG_RUN) begin
      clock_ready_flag <= 1'b0;
    end else if (state == SCDG_APPLY) begin
      clock_ready_flag <= 1'b1;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_event <= 1'b0;
    end else if (state == SCDG_APPLY) begin
      ready_event <= 1'b1;
    end else if (wr && ph_addr == SCDG_ICR && hwdata[SCDG_CLOCK_READY_FLAG_BIT]) begin
      ready_event <= 1'b0;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      interrupt_enable <= 1'b0;
    end else if (wr && ph_addr == SCDG_IER && hwdata[SCDG_CLOCK_READY_FLAG_BIT]) begin
      interrupt_enable <= 1'b1;
    end else if (wr && ph_addr == SCDG_IDR && hwdata[SCDG_CLOCK_READY_FLAG_BIT]) begin
      interrupt_enable <= 1'b0;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= ready_event && interrupt_enable;
    end
  end
  // ============================================================
  // Module clock masks; locked once own or bridge clock is masked
  assign mask_lock = !pba_mask[SCDG_PM_MASK_BIT] || !pba_mask[SCDG_BRIDGE_MASK_BIT];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_mask <= SCDG_MASK_RESET;
      hsb_mask <= SCDG_MASK_RESET;
      pba_mask <= SCDG_MASK_RESET;
      pbb_mask <= SCDG_MASK_RESET;
    end else if (wr && !mask_lock) begin
      if (ph_addr == SCDG_CPU_MASK) begin
        cpu_mask <= hwdata;
      end
      if (ph_addr == SCDG_HSB_MASK) begin
        hsb_mask <= hwdata;
      end
      if (ph_addr == SCDG_PBA_MASK) begin
        pba_mask <= hwdata;
      end
      if (ph_addr == SCDG_PBB_MASK) begin
        pbb_mask <= hwdata;
      end
    end
  end
  // ============================================================
  // Sleep control; wake sources from stopped PB domains are ignored
  always_comb begin
    wake = |(wake_irq & ~(wake_domain_pb & {SCDG_WAKE_W{sleep_mode >= 3'h2}}));
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleeping <= 1'b0;
      sleep_mode <= 3'h0;
    end else if (sleeping && wake) begin
      sleeping <= 1'b0;
    end else if (!sleeping && sleep_req && sleep_arg <= SCDG_MODE_MAX) begin
      sleeping <= 1'b1;
      sleep_mode <= sleep_arg;
    end
  end
  always_comb begin
    run = {SCDG_DOMAINS{1'b1}};
    if (sleeping) begin
      run[SCDG_D_CPU] = 1'b0;
      run[SCDG_D_HSB] = sleep_mode < 3'h1;
      run[SCDG_D_PBA] = sleep_mode < 3'h2;
      run[SCDG_D_PBB] = sleep_mode < 3'h2;
    end
  end
  scdg_div u_div_cpu (.hclk(hclk), .hresetn(hresetn), .count(prescale), .sel(act_cpu),
                      .run(run[SCDG_D_CPU]), .tick(ticks[SCDG_D_CPU]));
  // Fast bus shares the CPU source clock
  scdg_div u_div_hsb (.hclk(hclk), .hresetn(hresetn), .count(prescale), .sel(act_cpu),
                      .run(run[SCDG_D_HSB]), .tick(ticks[SCDG_D_HSB]));
  scdg_div u_div_pba (.hclk(hclk), .hresetn(hresetn), .count(prescale), .sel(act_pba),
                      .run(run[SCDG_D_PBA]), .tick(ticks[SCDG_D_PBA]));
  scdg_div u_div_pbb (.hclk(hclk), .hresetn(hresetn), .count(prescale), .sel(act_pbb),
                      .run(run[SCDG_D_PBB]), .tick(ticks[SCDG_D_PBB]));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      domain_tick <= '0;
      cpu_clk_en <= '0;
      hsb_clk_en <= '0;
      pba_clk_en <= '0;
      pbb_clk_en <= '0;
    end else begin
      domain_tick <= ticks;
      // Sleep overrides masks; masked module gets no clock, so no access lands
      cpu_clk_en <= cpu_mask & {SCDG_MASK_W{ticks[SCDG_D_CPU]}};
      hsb_clk_en <= hsb_mask & {SCDG_MASK_W{ticks[SCDG_D_HSB]}};
      pba_clk_en <= pba_mask & {SCDG_MASK_W{ticks[SCDG_D_PBA]}};
      pbb_clk_en <= pbb_mask & {SCDG_MASK_W{ticks[SCDG_D_PBB]}};
    end
  end
  // ============================================================
  // Reset sources: external pin synchronised before use
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_rst_q1 <= 1'b1;
      ext_rst_q2 <= 1'b1;
    end else begin
      ext_rst_q1 <= ext_reset_n;
      ext_rst_q2 <= ext_rst_q1;
    end
  end
  scdg_reset u_reset (.hclk(hclk), .hresetn(hresetn),
                      .sources({soft_sources[SCDG_NUM_RST-2:1], !ext_rst_q2, soft_sources[0]}),
                      .soft_reset(soft_reset), .cause(cause));
  // ============================================================
  // Read mux; unmapped offsets read zero
  always_comb begin
    next_rdata = 32'h00000000;
    unique case (ph_addr)
      SCDG_MAIN_CLOCK_CONTROL: next_rdata = {29'h0, main_clock_source_select};
      SCDG_CPU_SEL: next_rdata = {24'h0, cpu_sel};
      SCDG_FAST_BUS_SEL: next_rdata = {24'h0, cpu_sel};
      SCDG_PBA_SEL: next_rdata = {24'h0, pba_sel};
      SCDG_PBB_SEL: next_rdata = {24'h0, pbb_sel};
      SCDG_CPU_MASK: next_rdata = cpu_mask;
      SCDG_HSB_MASK: next_rdata = hsb_mask;
      SCDG_PBA_MASK: next_rdata = pba_mask;
      SCDG_PBB_MASK: next_rdata = pbb_mask;
      SCDG_IMR: next_rdata = {26'h0, interrupt_enable, 5'h0};
      SCDG_ISR: next_rdata = {26'h0, clock_ready_flag && ready_event, 5'h0};
      SCDG_SLEEP: next_rdata = {28'h0, sleeping, sleep_mode};
      SCDG_RESET_CAUSE: next_rdata = {28'h0, cause};
      default: next_rdata = 32'h00000000;
    endcase
  end
  // Loaded in the wait state; stands until the next read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (ph_rd && !hreadyout) begin
      hrdata <= next_rdata;
    end
  end
  logic unused;
  assign unused = ^{hsize, apply_cnt, haddr[31:8]};
endmodule // scdg_top
`default_nettype wire

/* sync_clock_divider_and_gating_tb.sv */
// Self-checking bench for scdg_top: bus reads, divider rates, masks, sleep.
// Assumes hreadyout answers; read data taken at the edge that ends the data phase.
`timescale 1ns/1ps
`default_nettype none
module sync_clock_divider_and_gating_tb;
  import scdg_pkg::*;
  logic hclk, hresetn, hsel, hwrite, rd_vld, go, pb, held, ext_n;
  logic hreadyout, hresp, sleep_req, soft_reset, irq, sleeping;
  logic [31:0] haddr, hwdata, hrdata, lf, d, cpu_en, hsb_en, pba_en, pbb_en;
  logic [1:0] htrans;
  logic [2:0] md, sleep_arg, src;
  logic [7:0] wake_irq, wake_pb;
  logic [3:0] tick;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int fails, num_checks;
  initial hclk = 1'b0;
  always #12.5 hclk = ~hclk;
  scdg_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .sleep_req(sleep_req), .sleep_arg(sleep_arg),
    .wake_irq(wake_irq), .wake_domain_pb(wake_pb), .ext_reset_n(ext_n), .soft_sources(3'h0),
    .main_clock_source_select(src), .domain_tick(tick), .cpu_clk_en(cpu_en),
    .hsb_clk_en(hsb_en), .pba_clk_en(pba_en), .pbb_clk_en(pbb_en), .sleeping(sleeping),
    .soft_reset(soft_reset), .irq(irq));
  scdg_cpu_model u_cpu (.hclk(hclk), .go(go), .mode(md), .pb(pb), .sleeping(sleeping),
    .sleep_req(sleep_req), .sleep_arg(sleep_arg), .wake_irq(wake_irq),
    .wake_domain_pb(wake_pb), .held(held));
  // ====
  // Tasks
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    d = hrdata;
  endtask
  // Mask zero means poll only: the value goes to d and no note is queued
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(a, 1'b0, 32'h0);
    if (m != 32'h0) begin
      exp_q.push_back(e & m);
      msk_q.push_back(m);
      rd_vld <= 1'b1;
      @(posedge hclk);
      rd_vld <= 1'b0;
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    d = 32'h0;
    while (d[SCDG_CLOCK_READY_FLAG_BIT] !== 1'b1 && n < 100) begin
      rd(SCDG_ISR, 32'h0, 32'h0);
      n++;
    end
    chk({31'h0, d[SCDG_CLOCK_READY_FLAG_BIT]}, 32'h1);
  endtask
  task automatic rates(input int e [4]);
    int n [4];
    n = '{0, 0, 0, 0};
    repeat (256) begin
      @(negedge hclk);
      for (int i = 0; i < 4; i++) n[i] += int'(tick[i]);
    end
    for (int i = 0; i < 4; i++) chk(n[i], e[i]);
  endtask
  task automatic results();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ====
  // Result watcher
  always @(negedge hclk) begin
    if (rd_vld === 1'b1 && exp_q.size() > 0) chk(hrdata & msk_q.pop_front(), exp_q.pop_front());
  end
  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    results();
  end
  // ====
  // Main sequence
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, rd_vld, go, pb, ext_n} = 6'h1;
    {haddr, hwdata} = 64'h0;
    htrans = 2'b00;
    md = 3'h0;
    fails = 0;
    num_checks = 0;
    lf = 32'hA9F8;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    chk({29'h0, src}, 32'h0);
    rates('{256, 256, 256, 256});
    for (int i = 0; i < 4; i++) rd(SCDG_CPU_MASK + 8'(4 * i), 32'hFFFFFFFF, '1);
    rd(SCDG_RESET_CAUSE, 32'h1, 32'h1);
    rd(8'h7C, 32'h0, '1);
    $display("test reset done");
    bus(SCDG_IER, 1'b1, 32'h20);
    bus(SCDG_PBB_SEL, 1'b1, 32'h87);
    wait_ready();
    bus(SCDG_ICR, 1'b1, 32'h20);
    // Line up with the slowest tap so the next change pends long enough to be seen
    repeat (300) if (tick[3] !== 1'b1) @(negedge hclk);
    bus(SCDG_CPU_SEL, 1'b1, 32'h81);
    rd(SCDG_ISR, 32'h0, 32'h20);
    wait_ready();
    chk({31'h0, irq}, 32'h1);
    bus(SCDG_FAST_BUS_SEL, 1'b1, 32'h05);
    rd(SCDG_FAST_BUS_SEL, 32'h81, 32'hFF);
    bus(SCDG_PBA_SEL, 1'b1, 32'h82);
    wait_ready();
    rates('{64, 64, 32, 1});
    bus(SCDG_ICR, 1'b1, 32'h20);
    repeat (3) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    bus(SCDG_PBA_SEL, 1'b1, 32'h81);
    wait_ready();
    rates('{64, 64, 64, 1});
    $display("test divider done");
    lf = lfsr(lfsr(lf));
    bus(SCDG_HSB_MASK, 1'b1, lf);
    rd(SCDG_HSB_MASK, lf, '1);
    @(negedge hclk);
    repeat (8) if (tick[1] !== 1'b1) @(negedge hclk);
    chk(hsb_en, lf);
    bus(SCDG_PBA_MASK, 1'b1, 32'hFFFFFFFE);
    bus(SCDG_HSB_MASK, 1'b1, 32'hFFFFFFFF);
    rd(SCDG_HSB_MASK, lf, '1);
    $display("test mask done");
    for (int m = 0; m < 8; m++) begin
      @(posedge hclk);
      md <= m[2:0];
      pb <= m[0];
      go <= 1'b1;
      @(posedge hclk);
      go <= 1'b0;
      repeat (40) @(posedge hclk);
      chk({31'h0, held}, {31'h0, m == 3 || m == 5});
    end
    ext_n <= 1'b0;
    repeat (3) @(posedge hclk);
    ext_n <= 1'b1;
    rd(SCDG_RESET_CAUSE, 32'h2, 32'hF);
    bus(SCDG_MAIN_CLOCK_CONTROL, 1'b1, 32'h0);
    chk({29'h0, src}, 32'h0);
    $display("test sleep done");
    hresetn <= 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    rd(SCDG_PBA_MASK, 32'hFFFFFFFF, '1);
    $display("test second reset done");
    results();
  end
endmodule // sync_clock_divider_and_gating_tb
`default_nettype wire
